// ===== spbc_pkg.sv
// Constants and carrier types for the sequential pointer buffer control
// Contract
// - Jump-start input loads matching buffer start address
// - Low load strobe captures sequential data lines
// - Pointer takes captured value next cycle, no advance
// - Read data ready one edge later after strobe
// - Active-low reset clears control state without clock
// - Reset gives documented pointer, flag, buffer defaults
// - Select lines and direction choose command target
// - Low direction writes; upper address, data ignored
// - Address registers read 1110 above twelve bits
// - Chaining: flag at end, jump to other start
// - Stop mode: flag at end, halt one past end while counting
// - Stopped pointer blocks sequential writes
// - Flow bits pick each buffer's mode
// - Writing release bit zero resumes at end plus two
// - Count must advance right after release or stay
// - Reset, strobe or jump-start also release pointer
// - Equal ends: both flags, chain to buffer one
// - Writing zero clears selected end flag
// - Writing one leaves end flag unchanged
// - Status bit reads one once flag set
// - Reserved command read returns all ones
package spbc_pkg;
  localparam int AW = 12;
  localparam int DW = 16;
  localparam logic [2:0] SEL_B1_START = 3'h0;
  localparam logic [2:0] SEL_B1_END = 3'h1;
  localparam logic [2:0] SEL_B2_START = 3'h2;
  localparam logic [2:0] SEL_B2_END = 3'h3;
  localparam logic [2:0] SEL_FLOW = 3'h4;
  localparam logic [2:0] SEL_FLAG = 3'h5;
  localparam logic [1:0] MODE_CHAIN = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam int FLOW_RELEASE_BIT = 4;
  localparam int FLAG_ONE_BIT = 0;
  localparam int FLAG_TWO_BIT = 1;
  localparam logic [11:0] RST_PTR = 12'h000;
  localparam logic [11:0] RST_B1_START = 12'h000;
  localparam logic [11:0] RST_B1_END = 12'hfff;
  localparam logic [11:0] RST_B2_START = 12'h000;
  localparam logic [11:0] RST_B2_END = 12'hfff;
  localparam logic [3:0] RST_FLOW = 4'h0;
  localparam logic [1:0] RST_FLAG_N = 2'h3;
  localparam logic RST_SEL_N = 1'b1;
  localparam logic RST_RW = 1'b0;
  localparam logic [3:0] ADDR_READ_TOP = 4'he;
  localparam logic [15:0] RESERVED_READ = 16'hffff;
  localparam logic [11:0] RELEASE_STEP = 12'h002;
  localparam int FIFO_DEPTH = 4;
  typedef struct packed {
    logic cmd_n;
    logic rw;
    logic [2:0] sel;
    logic [15:0] data;
  } spbc_host_pins_type;
  typedef struct packed {
    logic [11:0] addr;
    logic [15:0] data;
  } spbc_seq_write_type;
  localparam int SEQ_WR_W = 28;
endpackage : spbc_pkg

// ===== spbc_control.sv
// Pointer, flow control, command registers and write FIFO
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module spbc_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] data_q [DEPTH];
  logic [WIDTH-1:0] data_up [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] kept;
  logic [DEPTH-1:0] lower;
  logic [DEPTH-1:0] next_vld;
  logic [DEPTH-1:0] slot;
  logic ready_q;
  wire pop = vld_q[0] & out_ready_i;
  wire push = in_valid_i & ready_q;

  assign kept = pop ? (vld_q >> 1) : vld_q;
  assign lower = {kept[DEPTH-2:0], 1'b1};
  assign next_vld = kept | slot;
  assign in_ready_o = ready_q;
  assign out_valid_o = vld_q[0];
  assign out_data_o = data_q[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    if (i < DEPTH - 1) begin : g_up
      assign data_up[i] = data_q[i+1];
    end else begin : g_last
      assign data_up[i] = data_q[i];
    end
    assign slot[i] = push & ~kept[i] & lower[i];
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        vld_q[i] <= 1'b0;
      end else begin
        vld_q[i] <= next_vld[i];
      end
    end
    always_ff @(posedge clock_i) begin
      if (slot[i]) begin
        data_q[i] <= in_data_i;
      end else if (pop) begin
        data_q[i] <= data_up[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= ~next_vld[DEPTH-1];
    end
  end
endmodule : spbc_fifo

////////////////////////////////////////////////////////////////////////////
module spbc_control (
  // Clock and resets
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic buf_reset_n_i,
  // Host command port pins
  input wire logic host_cmd_select_n_i,
  input wire logic host_read_write_i,
  input wire logic [2:0] register_select_lines_i,
  input wire logic [15:0] host_data_lines_i,
  output logic [15:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  // Sequential control
  input wire logic pointer_load_strobe_n_i,
  input wire logic jump_start_one_n_i,
  input wire logic jump_start_two_n_i,
  input wire logic count_advance_enable_n_i,
  input wire logic seq_port_select_n_i,
  input wire logic seq_read_write_i,
  input wire logic [15:0] seq_data_i,
  output logic [11:0] pointer_o,
  output logic pointer_valid_o,
  output logic pointer_stopped_o,
  output logic end_flag_one_n_o,
  output logic end_flag_two_n_o,
  output logic seq_write_ready_o,
  // Memory write stream
  output logic mem_write_valid_o,
  output logic [11:0] mem_write_addr_o,
  output logic [15:0] mem_write_data_o,
  input wire logic mem_write_ready_i
);
  spbc_pkg::spbc_host_pins_type hs1, hs2, hs3, hv;
  spbc_pkg::spbc_seq_write_type wr_q, fifo_out;
  logic [11:0] start1_q, end1_q, start2_q, end2_q;
  logic [11:0] ptr_q, data_in_q, stop_end_q;
  logic [3:0] flow_q;
  logic [1:0] flag_n_q;
  logic rel_bit_q, rel_arm_q, stopped_q, load_pend_q;
  logic ptr_valid_q, sel_n_q, rw_q, blk_q;
  logic wr_hold_q;
  logic [2:0] wr_sel_q;
  logic [15:0] wr_data_q;
  logic [15:0] rd_q;
  logic rd_oe_q;
  logic fifo_ready;
  logic fifo_valid;
  logic [11:0] next_ptr, next_stop_end;
  logic next_stopped;

  function automatic logic [15:0] addr_word(input logic [11:0] a);
    addr_word = {spbc_pkg::ADDR_READ_TOP, a};
  endfunction : addr_word

  ////////////////////////////////////////////////////////////////////////
  // Host pin sampling and command decode
  assign hv = hs3;
  wire stable = (hs2 == hs3);
  wire cmd_wr = stable & ~hv.cmd_n & ~hv.rw;
  wire cmd_rd = stable & ~hv.cmd_n & hv.rw;
  wire cmd_idle = stable & hv.cmd_n;
  wire commit = cmd_idle & wr_hold_q;
  wire wr_b1s = commit & (wr_sel_q == spbc_pkg::SEL_B1_START);
  wire wr_b1e = commit & (wr_sel_q == spbc_pkg::SEL_B1_END);
  wire wr_b2s = commit & (wr_sel_q == spbc_pkg::SEL_B2_START);
  wire wr_b2e = commit & (wr_sel_q == spbc_pkg::SEL_B2_END);
  wire wr_flow = commit & (wr_sel_q == spbc_pkg::SEL_FLOW);
  wire wr_flag = commit & (wr_sel_q == spbc_pkg::SEL_FLAG);
  wire clr1 = wr_flag & ~wr_data_q[spbc_pkg::FLAG_ONE_BIT];
  wire clr2 = wr_flag & ~wr_data_q[spbc_pkg::FLAG_TWO_BIT];
  wire release_wr = wr_flow & ~wr_data_q[spbc_pkg::FLOW_RELEASE_BIT];

  always_ff @(posedge clock_i or negedge buf_reset_n_i) begin
    if (!buf_reset_n_i) begin
      hs1 <= '{cmd_n: 1'b1, rw: 1'b1, sel: 3'h0, data: 16'h0000};
      hs2 <= '{cmd_n: 1'b1, rw: 1'b1, sel: 3'h0, data: 16'h0000};
      hs3 <= '{cmd_n: 1'b1, rw: 1'b1, sel: 3'h0, data: 16'h0000};
    end else begin
      hs1 <= '{cmd_n: host_cmd_select_n_i, rw: host_read_write_i,
               sel: register_select_lines_i, data: host_data_lines_i};
      hs2 <= hs1;
      hs3 <= hs2;
    end
  end

  always_ff @(posedge clock_i or negedge buf_reset_n_i) begin
    if (!buf_reset_n_i) begin
      wr_hold_q <= 1'b0;
      wr_sel_q <= 3'h0;
      wr_data_q <= 16'h0000;
    end else if (rst_i || commit) begin
      wr_hold_q <= 1'b0;
    end else if (cmd_wr) begin
      wr_hold_q <= 1'b1;
      wr_sel_q <= hv.sel;
      wr_data_q <= hv.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command register read
  logic [15:0] rd_word;
  always_comb begin
    case (hv.sel)
      spbc_pkg::SEL_B1_START: rd_word = addr_word(start1_q);
      spbc_pkg::SEL_B1_END: rd_word = addr_word(end1_q);
      spbc_pkg::SEL_B2_START: rd_word = addr_word(start2_q);
      spbc_pkg::SEL_B2_END: rd_word = addr_word(end2_q);
      spbc_pkg::SEL_FLOW: rd_word = {11'h000, rel_bit_q, flow_q};
      spbc_pkg::SEL_FLAG: rd_word = {14'h0000, ~flag_n_q};
      default: rd_word = spbc_pkg::RESERVED_READ;
    endcase
  end

  always_ff @(posedge clock_i or negedge buf_reset_n_i) begin
    if (!buf_reset_n_i) begin
      rd_q <= 16'h0000;
      rd_oe_q <= 1'b0;
    end else begin
      rd_q <= rd_word;
      rd_oe_q <= cmd_rd & ~rst_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer address and flow registers
  always_ff @(posedge clock_i or negedge buf_reset_n_i) begin
    if (!buf_reset_n_i) begin
      start1_q <= spbc_pkg::RST_B1_START;
      end1_q <= spbc_pkg::RST_B1_END;
      start2_q <= spbc_pkg::RST_B2_START;
      end2_q <= spbc_pkg::RST_B2_END;
      flow_q <= spbc_pkg::RST_FLOW;
      rel_bit_q <= 1'b0;
    end else if (rst_i) begin
      start1_q <= spbc_pkg::RST_B1_START;
      end1_q <= spbc_pkg::RST_B1_END;
      start2_q <= spbc_pkg::RST_B2_START;
      end2_q <= spbc_pkg::RST_B2_END;
      flow_q <= spbc_pkg::RST_FLOW;
      rel_bit_q <= 1'b0;
    end else begin
      if (wr_b1s) start1_q <= wr_data_q[11:0];
      if (wr_b1e) end1_q <= wr_data_q[11:0];
      if (wr_b2s) start2_q <= wr_data_q[11:0];
      if (wr_b2e) end2_q <= wr_data_q[11:0];
      if (wr_flow) flow_q <= wr_data_q[3:0];
      if (wr_flow) rel_bit_q <= wr_data_q[spbc_pkg::FLOW_RELEASE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer sequencing
  wire pointer_load_strobe = ~pointer_load_strobe_n_i;
  wire adv = ~count_advance_enable_n_i;
  wire jump1 = ~pointer_load_strobe & ~jump_start_one_n_i & jump_start_two_n_i;
  wire jump2 = ~pointer_load_strobe & jump_start_one_n_i & ~jump_start_two_n_i;
  wire hit1 = (ptr_q == end1_q);
  wire hit2 = (ptr_q == end2_q);
  wire [1:0] hit_mode = hit1 ? flow_q[1:0] : flow_q[3:2];
  wire hit_stop = (hit1 | hit2) & (hit_mode == spbc_pkg::MODE_STOP);
  wire [11:0] hit_end = hit1 ? end1_q : end2_q;
  wire [11:0] chain_to = hit1 & ~hit2 ? start2_q : start1_q;

  always_comb begin
    next_ptr = ptr_q;
    next_stopped = stopped_q;
    next_stop_end = stop_end_q;
    if (rst_i) begin
      next_ptr = spbc_pkg::RST_PTR;
      next_stopped = 1'b0;
    end else if (load_pend_q) begin
      next_ptr = data_in_q;
      next_stopped = 1'b0;
    end else if (pointer_load_strobe) begin
      next_stopped = 1'b0;
    end else if (jump1) begin
      next_ptr = start1_q;
      next_stopped = 1'b0;
    end else if (jump2) begin
      next_ptr = start2_q;
      next_stopped = 1'b0;
    end else if (stopped_q) begin
      if (rel_arm_q && adv) begin
        next_ptr = stop_end_q + spbc_pkg::RELEASE_STEP;
        next_stopped = 1'b0;
      end
    end else if (hit_stop) begin
      next_stopped = 1'b1;
      next_stop_end = hit_end;
      next_ptr = adv ? ptr_q + 12'h001 : ptr_q;
    end else if (adv) begin
      next_ptr = (hit1 | hit2) ? chain_to : ptr_q + 12'h001;
    end
  end

  wire [1:0] next_flag_n = rst_i ? spbc_pkg::RST_FLAG_N :
    {(flag_n_q[1] | clr2) & ~hit2, (flag_n_q[0] | clr1) & ~hit1};

  always_ff @(posedge clock_i or negedge buf_reset_n_i) begin
    if (!buf_reset_n_i) begin
      ptr_q <= spbc_pkg::RST_PTR;
      stopped_q <= 1'b0;
      stop_end_q <= spbc_pkg::RST_PTR;
      flag_n_q <= spbc_pkg::RST_FLAG_N;
      rel_arm_q <= 1'b0;
      data_in_q <= spbc_pkg::RST_PTR;
      load_pend_q <= 1'b0;
      ptr_valid_q <= 1'b1;
    end else begin
      ptr_q <= next_ptr;
      stopped_q <= next_stopped;
      stop_end_q <= next_stop_end;
      flag_n_q <= next_flag_n;
      rel_arm_q <= release_wr & stopped_q & ~rst_i;
      if (pointer_load_strobe) data_in_q <= seq_data_i[11:0];
      load_pend_q <= pointer_load_strobe & ~rst_i;
      ptr_valid_q <= ~pointer_load_strobe | rst_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequential write capture into the FIFO
  wire stall = fifo_valid & ~fifo_ready;
  assign fifo_valid = ~sel_n_q & ~rw_q & ~blk_q;

  always_ff @(posedge clock_i or negedge buf_reset_n_i) begin
    if (!buf_reset_n_i) begin
      sel_n_q <= spbc_pkg::RST_SEL_N;
      rw_q <= spbc_pkg::RST_RW;
      blk_q <= 1'b0;
      wr_q <= '0;
    end else if (rst_i) begin
      sel_n_q <= spbc_pkg::RST_SEL_N;
      rw_q <= spbc_pkg::RST_RW;
      blk_q <= 1'b0;
    end else if (!stall) begin
      sel_n_q <= seq_port_select_n_i;
      rw_q <= seq_read_write_i;
      blk_q <= stopped_q;
      wr_q <= '{addr: ptr_q, data: seq_data_i};
    end
  end

  spbc_fifo #(
    .WIDTH(spbc_pkg::SEQ_WR_W),
    .DEPTH(spbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_valid),
    .in_data_i(wr_q),
    .in_ready_o(fifo_ready),
    .out_valid_o(mem_write_valid_o),
    .out_data_o(fifo_out),
    .out_ready_i(mem_write_ready_i)
  );

  assign mem_write_addr_o = fifo_out.addr;
  assign mem_write_data_o = fifo_out.data;
  assign seq_write_ready_o = fifo_ready;
  assign pointer_o = ptr_q;
  assign pointer_valid_o = ptr_valid_q;
  assign pointer_stopped_o = stopped_q;
  assign end_flag_one_n_o = flag_n_q[0];
  assign end_flag_two_n_o = flag_n_q[1];
  assign host_data_lines_o = rd_q;
  assign host_data_lines_oe_o = rd_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  wire quiet = ~load_pend_q & ~rst_i;

  a_jump_one_load: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (jump1 && quiet) |=> ptr_q == $past(start1_q))
    else $error("jump start one did not load start");

  a_strobe_capture: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    pointer_load_strobe |=> data_in_q == $past(seq_data_i[11:0]))
    else $error("strobe data not captured");

  a_strobe_delay: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (pointer_load_strobe && quiet) |=> $stable(ptr_q) ##1 ptr_q == $past(data_in_q))
    else $error("strobe load timing wrong");

  a_ptr_ready: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (pointer_load_strobe && quiet) |=> !pointer_valid_o ##1 pointer_valid_o)
    else $error("pointer ready timing wrong");

  a_flag_match: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    hit1 |=> !end_flag_one_n_o)
    else $error("end flag one not asserted");

  a_stop_blocks: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (stopped_q && !stall) |=> !fifo_valid)
    else $error("write passed while stopped");

  a_release_jump: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (rel_arm_q && stopped_q && adv && quiet && !pointer_load_strobe && !jump1 && !jump2)
    |=> ptr_q == $past(stop_end_q) + 12'h002 && !stopped_q)
    else $error("release did not resume at end plus two");

  a_reserved_read: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (cmd_rd && hv.sel[2:1] == 2'b11) |=> host_data_lines_o == 16'hffff)
    else $error("reserved read not all ones");

  a_flag_clear: assert property (@(posedge clock_i)
    disable iff (rst_i || !buf_reset_n_i)
    (clr1 && !hit1) |=> end_flag_one_n_o)
    else $error("end flag one not cleared");
endmodule : spbc_control

// ===== spbc_mem_sink.sv
// Memory write sink that stalls at random or while held
`timescale 1ns/10ps

module spbc_mem_sink (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Stall control from the bench
  input wire logic hold_i,
  // Write stream ready
  output logic mem_write_ready_o
);
  // Ready drops at random so the buffer sees back-pressure
  always_ff @(posedge clock_i) begin
    if (rst_i || hold_i) begin
      mem_write_ready_o <= 1'b0;
    end else begin
      mem_write_ready_o <= ($urandom % 3) != 0;
    end
  end
endmodule : spbc_mem_sink

// ===== test_seq_pointer_buffer_control.sv
// Self-checking bench for the sequential pointer buffer control
`timescale 1ns/10ps

module test_seq_pointer_buffer_control;
  logic clock = 1'b0, rst = 1'b1, buf_rst_n = 1'b1, hold = 1'b1;
  logic cmd_n = 1'b1, hrw = 1'b1, ld_n = 1'b1, j1_n = 1'b1, j2_n = 1'b1;
  logic cnt_n = 1'b1, ssel_n = 1'b1, srw = 1'b1;
  logic [2:0] hsel = 3'h0;
  logic [15:0] hdata = 16'h0, sdata = 16'h0, hq, mdata, q;
  logic [11:0] ptr, maddr, s1, s2, e, d;
  logic hoe, pvalid, stopped, f1_n, f2_n, wready, mvalid, mready;
  logic [27:0] expq [$];
  int failures = 0;
  int n_checks = 0;
  int i;

  spbc_control u_spbc_control (
    .clock_i(clock), .rst_i(rst), .buf_reset_n_i(buf_rst_n),
    .host_cmd_select_n_i(cmd_n), .host_read_write_i(hrw),
    .register_select_lines_i(hsel), .host_data_lines_i(hdata),
    .host_data_lines_o(hq), .host_data_lines_oe_o(hoe),
    .pointer_load_strobe_n_i(ld_n), .jump_start_one_n_i(j1_n),
    .jump_start_two_n_i(j2_n), .count_advance_enable_n_i(cnt_n),
    .seq_port_select_n_i(ssel_n), .seq_read_write_i(srw),
    .seq_data_i(sdata), .pointer_o(ptr), .pointer_valid_o(pvalid),
    .pointer_stopped_o(stopped), .end_flag_one_n_o(f1_n),
    .end_flag_two_n_o(f2_n), .seq_write_ready_o(wready),
    .mem_write_valid_o(mvalid), .mem_write_addr_o(maddr),
    .mem_write_data_o(mdata), .mem_write_ready_i(mready)
  );

  spbc_mem_sink u_spbc_mem_sink (
    .clock_i(clock), .rst_i(rst), .hold_i(hold),
    .mem_write_ready_o(mready)
  );

  initial begin
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  // Command access; pins held until the window has settled
  task automatic cmd(input logic rw, input logic [2:0] s,
                     input logic [15:0] d16, input int post);
    @(posedge clock);
    cmd_n <= 1'b0;
    hrw <= rw;
    hsel <= s;
    hdata <= d16;
    cyc(6);
    #1 q = hq;
    if (rw) chk("host_oe", 16'h1, {15'h0, hoe});
    @(posedge clock);
    cmd_n <= 1'b1;
    cyc(post);
  endtask : cmd

  task automatic wait_for(input bit stop, input logic [11:0] v);
    for (int k = 0; k < 6000; k++) begin
      @(posedge clock);
      #1;
      if (stop ? stopped === v[0] : ptr === v) return;
    end
    failures++;
    complete_run();
  endtask : wait_for

  task automatic jump(input bit two, input logic [11:0] exp);
    @(posedge clock);
    if (two) j2_n <= 1'b0; else j1_n <= 1'b0;
    @(posedge clock);
    j1_n <= 1'b1;
    j2_n <= 1'b1;
    #1 chk("jump_pointer", {4'h0, exp}, {4'h0, ptr});
  endtask : jump

  task automatic reset_vals();
    logic [15:0] tbl [8] = '{16'he000, 16'hefff, 16'he000, 16'hefff,
                             16'h0000, 16'h0000, 16'hffff, 16'hffff};
    chk("reset_state", 16'h000d, {ptr, f1_n, f2_n, stopped, pvalid});
    for (int k = 0; k < 8; k++) begin
      cmd(1'b1, 3'(k), 16'($urandom), 7);
      chk("cmd_read", tbl[k], q);
    end
  endtask : reset_vals

  // Memory stream must match the accepted writes in order
  always @(posedge clock) begin
    if (mvalid === 1'b1 && mready === 1'b1) begin
      if (expq.size() == 0) begin
        chk("unexpected_write", 16'h0, 16'h1);
      end else begin
        chk("mem_addr", {4'h0, expq[0][27:16]}, {4'h0, maddr});
        chk("mem_data", expq[0][15:0], mdata);
        void'(expq.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h74fe));
    s1 = 12'($urandom) & 12'h7ff;
    s2 = 12'h900 | (12'($urandom) & 12'h1ff);
    d = 12'hc00 | (12'($urandom) & 12'h0ff);
    e = s1 + 12'h005;
    cyc(3);
    rst <= 1'b0;
    reset_vals();
    cmd(1'b0, 3'h0, {4'($urandom), s1}, 7);
    cmd(1'b0, 3'h1, {4'($urandom), e}, 7);
    cmd(1'b0, 3'h2, {4'($urandom), s2}, 7);
    cmd(1'b1, 3'h2, 16'h0, 7);
    chk("start_two", {4'he, s2}, q);
    jump(1'b1, s2);
    jump(1'b0, s1);
    // Chaining from buffer one into buffer two
    @(posedge clock);
    cnt_n <= 1'b0;
    wait_for(1'b0, e);
    @(posedge clock);
    cnt_n <= 1'b1;
    #1 chk("chain", {s2, 4'b0101}, {ptr, f1_n, f2_n, stopped, pvalid});
    cmd(1'b1, 3'h5, 16'h0, 7);
    chk("flag_status", 16'h0001, q);
    cmd(1'b0, 3'h3, {4'($urandom), e}, 7);
    cmd(1'b0, 3'h5, 16'hfffe, 7);
    chk("flags", 16'h3, {14'h0, f1_n, f2_n});
    // Equal end addresses
    jump(1'b0, s1);
    @(posedge clock);
    cnt_n <= 1'b0;
    wait_for(1'b0, e);
    @(posedge clock);
    cnt_n <= 1'b1;
    #1 chk("equal_end", {s1, 4'b0001}, {ptr, f1_n, f2_n, stopped, pvalid});
    cmd(1'b1, 3'h5, 16'h0, 7);
    chk("both_status", 16'h3, q);
    cmd(1'b0, 3'h5, 16'hfffe, 7);
    chk("keep_flag", 16'h2, {14'h0, f1_n, f2_n});
    cmd(1'b0, 3'h5, 16'hfffd, 7);
    chk("flags", 16'h3, {14'h0, f1_n, f2_n});
    // Stop mode, pointer halts past the end
    cmd(1'b0, 3'h4, 16'h0001, 7);
    cmd(1'b1, 3'h4, 16'h0, 7);
    chk("flow_read", 16'h0001, q);
    @(posedge clock);
    cnt_n <= 1'b0;
    wait_for(1'b0, e);
    cyc(4);
    #1 chk("stop_point", {e + 12'h1, 4'h1}, {ptr, f1_n, 2'h0, stopped});
    @(posedge clock);
    ssel_n <= 1'b0;
    srw <= 1'b0;
    sdata <= 16'($urandom);
    cyc(3);
    ssel_n <= 1'b1;
    srw <= 1'b1;
    cyc(4);
    #1 chk("blocked_write", 16'h0, {15'h0, mvalid});
    cmd(1'b0, 3'h4, 16'h0001, 0);
    wait_for(1'b1, 12'h0);
    chk("release", {4'h0, e + 12'h2}, {4'h0, ptr});
    jump(1'b0, s1);
    // Stop on the end itself, release refused without count
    wait_for(1'b0, e - 12'h1);
    @(posedge clock);
    cnt_n <= 1'b1;
    cyc(3);
    #1 chk("stop_end", {e, 4'h1}, {ptr, 3'h0, stopped});
    cmd(1'b0, 3'h4, 16'h0001, 8);
    chk("no_release", {e, 4'h1}, {ptr, 3'h0, stopped});
    jump(1'b1, s2);
    chk("jump_release", 16'h0, {15'h0, stopped});
    jump(1'b0, s1);
    @(posedge clock);
    cnt_n <= 1'b0;
    wait_for(1'b1, 12'h1);
    // Strobe load while stopped; jump inputs high, port deselected
    @(posedge clock);
    ld_n <= 1'b0;
    sdata <= {4'($urandom), d};
    cnt_n <= 1'b0;
    @(posedge clock);
    ld_n <= 1'b1;
    #1 chk("load_wait", {e + 12'h1, 4'h0},
           {ptr, 3'h0, pvalid});
    @(posedge clock);
    #1 chk("load_done", {d, 4'h1}, {ptr, 2'h0, stopped, pvalid});
    // Write stream: fill against a held sink, then drain
    cmd(1'b0, 3'h4, 16'h0, 7);
    jump(1'b1, s2);
    for (i = 0; i < 90; i++) begin
      @(posedge clock);
      if (ssel_n === 1'b0) begin
        expq.push_back({ptr, sdata});
        ssel_n <= 1'b1;
      end else if (i % 4 == 0 && wready === 1'b1 && i < 60) begin
        ssel_n <= 1'b0;
        srw <= 1'b0;
        sdata <= 16'($urandom);
      end
      if (i == 39) chk("fifo_full", 16'h0, {15'h0, wready});
      if (i == 40) hold <= 1'b0;
    end
    for (i = 0; i < 300 && expq.size() > 0; i++) cyc(1);
    #1 chk("fifo_empty", 16'h0, {15'h0, mvalid | (expq.size() > 0)});
    // Stop mode on buffer two alone
    cmd(1'b0, 3'h3, {4'($urandom), s2 + 12'h3}, 7);
    cmd(1'b0, 3'h5, 16'hfffd, 7);
    cmd(1'b0, 3'h4, 16'h0004, 7);
    jump(1'b1, s2);
    wait_for(1'b1, 12'h1);
    chk("stop_two", {s2 + 12'h4, 4'h1},
        {ptr, f2_n, 2'h0, stopped});
    // Reset pin acts without a clock edge
    @(posedge clock);
    cnt_n <= 1'b0;
    #2 buf_rst_n <= 1'b0;
    #1 chk("async_reset", 16'h000d, {ptr, f1_n, f2_n, stopped, pvalid});
    @(posedge clock);
    buf_rst_n <= 1'b1;
    cnt_n <= 1'b1;
    #1 reset_vals();
    complete_run();
  end
endmodule : test_seq_pointer_buffer_control
